//--- hw/iocb_bus_ctrl.sv
// Processor end of the I/O command/response bus, reached over APB.
// Assumes the peripheral controls drive the data bus only during the
// response strobe and release it when the strobe ends.
//
// Notes on behaviour
// - Usually one exchange per state, then advance.
// - Data states repeat exchanges, one/two bytes.
// - 24-bit data bus, 5-bit control bus.
// - Command word held two clocks with strobe.
// - Response strobe samples data from the control.
// - Command bits: type, channel, variant.
// - Control-type codes chosen by low variant nibble.
// - Types 2,3 send data; type 4 fetches.
// - Types 6,7 carry record byte counts.
// - Service flag ORed into summary bit 2.
// - Empty buffer gives state 7; else end-data.
// - Streaming: count, one command, many responses.
`timescale 1ns/1ps
module iocb_bus_ctrl #(
  parameter int IRQ_W = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  input  wire logic [23:0]      io_data_i,
  output logic      [23:0]      io_data_o,
  output logic                  io_data_oe_o,
  output logic                  command_active_strobe_o,
  output logic                  response_complete_strobe_o,
  output logic                  bus_valid_o,
  input  wire logic             service_request_i,
  input  wire logic [IRQ_W-1:0] other_irq_i
);
  typedef enum logic [3:0] {
    IOCB_IDLE = 4'b0001,
    IOCB_CMD  = 4'b0010,
    IOCB_RESP = 4'b0100,
    IOCB_DONE = 4'b1000
  } iocb_state_type;

  iocb_state_type state_q;
  iocb_state_type state_d;
  logic [3:0]       cnt_q;
  logic [3:0]       cnt_d;
  logic [23:0]      out_word_q;
  logic             oe_q;
  logic             ca_q;
  logic             rc_q;
  logic [23:0]      in_word_q;
  logic             pending_q;
  logic [3:0]       last_type_q;
  logic [15:0]      stream_q;
  logic             stream_en_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [23:0]      io_sync;
  logic             svc_sync;
  logic [IRQ_W-1:0] irq_sync;
  logic [3:0]       cmd_type;
  logic             dec_end;
  logic             dec_odd;
  logic             dec_outcnt;
  logic             dec_incnt;

  localparam int COUNT_W_L = iocb_pkg::COUNT_W;
  localparam logic [3:0] CMD_LAST =
    4'(iocb_pkg::CMD_HOLD_CLKS - 1);
  localparam logic [3:0] RESP_LAST =
    4'(iocb_pkg::RESP_CLKS - 1);

  // Pin levels from the controls cross into the clock domain first.
  iocb_sync #(.WIDTH(24)) u_sync_data (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (io_data_i),
    .q_o   (io_sync)
  );
  iocb_sync #(.WIDTH(IRQ_W + 1)) u_sync_irq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({other_irq_i, service_request_i}),
    .q_o   ({irq_sync, svc_sync})
  );

  // The command word is classified as it is written.
  iocb_cmd_decode u_dec (
    .word_i      (pwdata_i[23:0]),
    .cmd_type_o  (cmd_type),
    .channel_o   (),
    .variant_o   (),
    .end_data_o  (dec_end),
    .odd_byte_o  (dec_odd),
    .out_count_o (dec_outcnt),
    .in_count_o  (dec_incnt)
  );

  // APB decode. Exchanges start only from idle so a held request is
  // taken once and answered from the done state.
  logic acc;
  logic hit_out;
  logic hit_in;
  logic hit_cond;
  logic hit_ctl;
  logic hit_strm;
  logic mapped;
  logic start_cmd;
  logic start_resp;
  logic plain;
  assign acc        = psel_i && penable_i;
  assign hit_out    = (paddr_i == iocb_pkg::OFS_BUS_OUT);
  assign hit_in     = (paddr_i == iocb_pkg::OFS_BUS_IN);
  assign hit_cond   = (paddr_i == iocb_pkg::OFS_CONDITION);
  assign hit_ctl    = (paddr_i == iocb_pkg::OFS_CONTROL);
  assign hit_strm   = (paddr_i == iocb_pkg::OFS_STREAM);
  assign mapped     = hit_out || hit_in || hit_cond || hit_ctl || hit_strm;
  assign start_cmd  = acc && pwrite_i && hit_out && (state_q == IOCB_IDLE);
  assign start_resp = acc && !pwrite_i && hit_in && (state_q == IOCB_IDLE);
  assign plain      = !((hit_out && pwrite_i) || (hit_in && !pwrite_i));
  assign pready_o   = plain ? acc : (state_q == IOCB_DONE);
  assign pslverr_o  = acc && !mapped;

  // Summary interrupt: service request ORed with other enabled sources.
  logic any_irq;
  assign any_irq = svc_sync || (|(irq_sync & irq_mask_q));

  // Sequence-state classes of the last response word.
  logic [4:0] seq_state;
  logic       in_data_st;
  logic       last_st;
  logic       ref_st;
  assign seq_state  = in_word_q[iocb_pkg::RSP_STATE_LSB +: 5];
  assign in_data_st = (seq_state == iocb_pkg::SEQ_DATA_IN) ||
                      (seq_state == iocb_pkg::SEQ_DATA_OUT);
  assign last_st    = (seq_state == iocb_pkg::SEQ_LAST_MORE) ||
                      (seq_state == iocb_pkg::SEQ_LAST_FINAL);
  assign ref_st     = (seq_state == iocb_pkg::SEQ_REF_RECV);

  // Condition pseudoregister as seen by software.
  logic [31:0] cond_word;
  always_comb begin
    cond_word = 32'h00000000;
    cond_word[iocb_pkg::COND_PENDING] = pending_q;
    cond_word[iocb_pkg::COND_SERVICE] = svc_sync;
    cond_word[iocb_pkg::COND_ANY_IRQ] = any_irq;
    cond_word[iocb_pkg::COND_STREAM]  = (stream_q != 16'h0000);
    cond_word[iocb_pkg::COND_DATA_ST] = in_data_st;
    cond_word[iocb_pkg::COND_LAST_ST] = last_st;
    cond_word[iocb_pkg::COND_REF_ST]  = ref_st;
    cond_word[iocb_pkg::COND_STATE_LSB +: 5] = seq_state;
    cond_word[iocb_pkg::COND_TOG_LSB +: 3] =
      in_word_q[iocb_pkg::RSP_TOG_LSB +: 3];
    cond_word[iocb_pkg::COND_TYPE_LSB +: 4] = last_type_q;
  end

  // Read data mux; unmapped reads return zero.
  assign prdata_o = hit_in   ? {8'h00, in_word_q} :
                    hit_cond ? cond_word :
                    hit_ctl  ? {{(31 - IRQ_W){1'b0}}, irq_mask_q,
                                stream_en_q} :
                    hit_strm ? {16'h0000, stream_q} :
                    32'h00000000;

  // Exchange sequencer. A command write drives the word with the
  // command strobe for a fixed hold; a response read raises the
  // response strobe long enough for the synchronised bus to settle.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      IOCB_IDLE: begin
        if (start_cmd) begin
          state_d = IOCB_CMD;
          cnt_d   = CMD_LAST;
        end else if (start_resp) begin
          state_d = IOCB_RESP;
          cnt_d   = RESP_LAST;
        end
      end
      IOCB_CMD: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          state_d = IOCB_DONE;
        end
      end
      IOCB_RESP: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          state_d = IOCB_DONE;
        end
      end
      IOCB_DONE: begin
        state_d = IOCB_IDLE;
      end
      default: begin
        state_d = IOCB_IDLE;
      end
    endcase
  end

  logic cmd_end;
  logic resp_end;
  assign cmd_end  = (state_q == IOCB_CMD) && (cnt_q == 4'h0);
  assign resp_end = (state_q == IOCB_RESP) && (cnt_q == 4'h0);

  // Sequencer state and hold counter.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= IOCB_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // The processor drives the bus only while the command strobe is up.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_word_q <= iocb_pkg::WORD_RESET;
      oe_q       <= 1'b0;
      ca_q       <= 1'b0;
      rc_q       <= 1'b0;
    end else begin
      if (start_cmd) begin
        out_word_q <= pwdata_i[23:0];
      end
      oe_q <= start_cmd || ((state_q == IOCB_CMD) && !cmd_end);
      ca_q <= start_cmd || ((state_q == IOCB_CMD) && !cmd_end);
      rc_q <= start_resp || ((state_q == IOCB_RESP) && !resp_end);
    end
  end

  // Response capture and exchange pairing. The word kept is the one
  // on the bus in the second clock of the strobe, so the state it reports is
  // the state the control held during this exchange.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_word_q   <= iocb_pkg::WORD_RESET;
      pending_q   <= 1'b0;
      last_type_q <= 4'h0;
    end else begin
      if (resp_end) begin
        in_word_q <= io_sync;
      end
      if (start_cmd) begin
        last_type_q <= cmd_type;
      end
      if (start_cmd) begin
        pending_q <= 1'b1;
      end else if (resp_end && (stream_q <= 16'h0001)) begin
        pending_q <= 1'b0;
      end
    end
  end

  // Streamed transfers. A byte count sent or received sets how many
  // three-byte responses follow one command; each response read after a
  // type 3 or 4 command uses one, and end-data cancels the remainder.
  logic [COUNT_W_L-1:0] out_count;
  logic [COUNT_W_L-1:0] in_count;
  logic [15:0]          out_rcs;
  logic [15:0]          in_rcs;
  assign out_count = pwdata_i[iocb_pkg::COUNT_LSB +: COUNT_W_L];
  assign in_count  = io_sync[iocb_pkg::COUNT_LSB +: COUNT_W_L];
  assign out_rcs   = 16'((16'(out_count) + 16'h0002) / 16'h0003);
  assign in_rcs    = 16'((16'(in_count) + 16'h0002) / 16'h0003);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stream_q <= iocb_pkg::STREAM_RESET;
    end else if (start_cmd && dec_end) begin
      stream_q <= iocb_pkg::STREAM_RESET;
    end else if (start_cmd && dec_outcnt && stream_en_q) begin
      stream_q <= out_rcs;
    end else if (resp_end && (last_type_q == iocb_pkg::TYPE_IN_COUNT) &&
                 stream_en_q && (stream_q == 16'h0000)) begin
      stream_q <= in_rcs;
    end else if (resp_end && (stream_q != 16'h0000) &&
                 ((last_type_q == iocb_pkg::TYPE_OUT_B) ||
                  (last_type_q == iocb_pkg::TYPE_IN))) begin
      stream_q <= stream_q - 16'h0001;
    end
  end

  // Control register: streaming enable and other-source mask.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stream_en_q <= 1'b0;
      irq_mask_q  <= '0;
    end else if (acc && pwrite_i && hit_ctl) begin
      stream_en_q <= pwdata_i[0];
      irq_mask_q  <= pwdata_i[IRQ_W:1];
    end
  end

  // The odd-byte notice and the type-6 incount decode are only
  // forwarded over the bus; the controls act on them.
  logic unused_ok;
  assign unused_ok = dec_odd ^ dec_incnt;

  assign io_data_o                  = out_word_q;
  assign io_data_oe_o               = oe_q;
  assign command_active_strobe_o    = ca_q;
  assign response_complete_strobe_o = rc_q;
  assign bus_valid_o                = ca_q;
endmodule

//--- hw/iocb_cmd_decode.sv
// Field split and classification of one command word.
// Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ps
module iocb_cmd_decode (
  input  wire logic [23:0] word_i,
  output logic      [3:0]  cmd_type_o,
  output logic      [3:0]  channel_o,
  output logic      [15:0] variant_o,
  output logic             end_data_o,
  output logic             odd_byte_o,
  output logic             out_count_o,
  output logic             in_count_o
);
  logic is_ctl;

  // Type, channel and variant sit in fixed fields of the word.
  assign cmd_type_o  = word_i[iocb_pkg::CMD_TYPE_LSB +: 4];
  assign channel_o   = word_i[iocb_pkg::CMD_CHAN_LSB +: 4];
  assign variant_o   = word_i[iocb_pkg::CMD_VAR_LSB +: 16];
  // Control-type codes are picked by the low nibble of the variant.
  assign is_ctl      = (cmd_type_o == iocb_pkg::TYPE_CONTROL);
  assign end_data_o  = is_ctl && (variant_o[3:0] == iocb_pkg::VAR_END_DATA);
  assign odd_byte_o  = is_ctl && (variant_o[3:0] == iocb_pkg::VAR_ODD_BYTE);
  assign out_count_o = (cmd_type_o == iocb_pkg::TYPE_OUT_COUNT);
  assign in_count_o  = (cmd_type_o == iocb_pkg::TYPE_IN_COUNT);
endmodule

//--- hw/iocb_pkg.sv
// Shared constants for the processor side of the I/O command/response bus.
// Assumes a 25 MHz system clock and APB register access with 32-bit data.
package iocb_pkg;

  // Register byte offsets on the APB side.
  localparam logic [7:0] OFS_BUS_OUT    = 8'h00;
  localparam logic [7:0] OFS_BUS_IN     = 8'h04;
  localparam logic [7:0] OFS_CONDITION  = 8'h08;
  localparam logic [7:0] OFS_CONTROL    = 8'h0C;
  localparam logic [7:0] OFS_STREAM     = 8'h10;

  // Timing of the two halves of an exchange; clock in MHz, response in ns, hold and response lengths in clock cycles.
  localparam int CLK_MHZ        = 25;
  localparam int CMD_HOLD_CLKS  = 2;
  localparam int RESP_NS        = 160;
  localparam int RESP_CLKS      = (RESP_NS * CLK_MHZ) / 1000;

  // Command word fields.
  localparam int CMD_TYPE_LSB   = 0;
  localparam int CMD_CHAN_LSB   = 4;
  localparam int CMD_VAR_LSB    = 8;
  // Response word fields.
  localparam int RSP_TOG_LSB    = 0;
  localparam int RSP_STATE_LSB  = 3;
  // Byte count field shared by the two byte-count exchanges.
  localparam int COUNT_LSB      = 15;
  localparam int COUNT_W        = 9;

  // Command types.
  localparam logic [3:0] TYPE_CONTROL   = 4'h1;
  localparam logic [3:0] TYPE_OUT_A     = 4'h2;
  localparam logic [3:0] TYPE_OUT_B     = 4'h3;
  localparam logic [3:0] TYPE_IN        = 4'h4;
  localparam logic [3:0] TYPE_IN_COUNT  = 4'h6;
  localparam logic [3:0] TYPE_OUT_COUNT = 4'h7;

  // Variant codes of the control type, low variant nibble.
  localparam logic [3:0] VAR_QUERY      = 4'h1;
  localparam logic [3:0] VAR_ODD_BYTE   = 4'h2;
  localparam logic [3:0] VAR_CLEAR      = 4'h3;
  localparam logic [3:0] VAR_POLL       = 4'h5;
  localparam logic [3:0] VAR_END_DATA   = 4'h6;

  // Sequence states of interest.
  localparam logic [4:0] SEQ_REF_RECV   = 5'h07;
  localparam logic [4:0] SEQ_DATA_IN    = 5'h0E;
  localparam logic [4:0] SEQ_DATA_OUT   = 5'h0F;
  localparam logic [4:0] SEQ_LAST_MORE  = 5'h10;
  localparam logic [4:0] SEQ_LAST_FINAL = 5'h11;

  // Condition register bit positions.
  localparam int COND_PENDING   = 0;
  localparam int COND_SERVICE   = 1;
  localparam int COND_ANY_IRQ   = 2;
  localparam int COND_STREAM    = 3;
  localparam int COND_DATA_ST   = 4;
  localparam int COND_LAST_ST   = 5;
  localparam int COND_REF_ST    = 6;
  localparam int COND_STATE_LSB = 8;
  localparam int COND_TOG_LSB   = 13;
  localparam int COND_TYPE_LSB  = 16;

  // Reset values.
  localparam logic [23:0] WORD_RESET    = 24'h000000;
  localparam logic [15:0] STREAM_RESET  = 16'h0000;

endpackage

//--- hw/iocb_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk_i; the first stage feeds
// only the second.
`timescale 1ns/1ps
module iocb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Both stages clear on reset so the outputs are defined at once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

//--- testbench/iocb_bus_ctrl_monitor.sv
// Concurrent checks on the processor end of the command/response bus.
// Assumes it is bound to iocb_bus_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module iocb_bus_ctrl_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        pready_o,
  input wire logic [23:0] io_data_o,
  input wire logic        io_data_oe_o,
  input wire logic        command_active_strobe_o,
  input wire logic        response_complete_strobe_o,
  input wire logic        bus_valid_o
);
  logic ca;
  logic rc;
  logic acc;

  // Short names; an access is only a launch while no exchange is running.
  assign ca  = command_active_strobe_o;
  assign rc  = response_complete_strobe_o;
  assign acc = psel_i && penable_i && !ca && !rc && !pready_o;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ca_two_clk: assert property ($rose(ca) |=> ca ##1 !ca)
    else $error("command strobe not two cycles long");
  a_word_held: assert property (
    $rose(ca) |=> $stable(io_data_o))
    else $error("command word changed under the strobe");
  a_oe_with_ca: assert property (io_data_oe_o == ca)
    else $error("bus drive differs from command strobe");
  a_valid_is_ca: assert property (bus_valid_o == ca)
    else $error("valid line differs from command strobe");
  a_strobes_apart: assert property (!(ca && rc))
    else $error("command and response strobes overlap");
  a_rc_four_clk: assert property (
    $rose(rc) |-> rc [*4] ##1 !rc)
    else $error("response strobe not four cycles long");
  a_write_launch: assert property (
    acc && pwrite_i && paddr_i == 8'h00 |=> $rose(ca))
    else $error("bus-out write did not start a command");
  a_read_launch: assert property (
    acc && !pwrite_i && paddr_i == 8'h04 |=> $rose(rc))
    else $error("bus-in read did not start a response");
  a_write_done: assert property ($rose(ca) |-> ##2 pready_o)
    else $error("command write not finished on time");
  a_read_done: assert property (
    $rose(rc) |-> ##4 (pready_o && !rc))
    else $error("response read not finished on time");
endmodule

bind iocb_bus_ctrl iocb_bus_ctrl_monitor mon_i (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o),
  .io_data_o(io_data_o), .io_data_oe_o(io_data_oe_o),
  .command_active_strobe_o(command_active_strobe_o),
  .response_complete_strobe_o(response_complete_strobe_o),
  .bus_valid_o(bus_valid_o));

//--- testbench/iocb_bus_ctrl_tb_top.sv
// Self-checking bench for the processor end of the command/response bus.
// Assumes the peripheral model and the bound checker are compiled first.
`timescale 1ns/1ps
module iocb_bus_ctrl_tb_top;
  logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic        oe, ca, rc, valid, srq, want_srv, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] bus_in, bus_out, last_cmd;
  logic [3:0]  irq;
  logic [4:0]  state;
  int          error_cnt, n_tests;
  // Command words and the responses the model gives in state 1.
  logic [23:0] cmds [10] = '{24'h000151, 24'h000251, 24'h000351,
    24'h000501, 24'h000651, 24'hBEEF52, 24'h000053, 24'h000054,
    24'h000056, 24'h001257};
  logic [23:0] rsps [10] = '{24'h2A5C08, 24'h000008, 24'h2A5C08,
    24'h040008, 24'h000008, 24'h000008, 24'h000008, 24'hC3A51E,
    24'h048008, 24'h000008};
  logic [4:0]  sts [5] = '{5'h0E, 5'h0F, 5'h10, 5'h11, 5'h07};

  iocb_bus_ctrl #(.IRQ_W(4)) iocb_bus_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .io_data_i(bus_in), .io_data_o(bus_out), .io_data_oe_o(oe),
    .command_active_strobe_o(ca), .response_complete_strobe_o(rc),
    .bus_valid_o(valid), .service_request_i(srq), .other_irq_i(irq));

  iocb_periph_model #(.ODD_REC(1'b1)) iocb_periph_model_i (
    .clk_i(clk_i), .ca_i(ca), .rc_i(rc), .word_i(bus_out),
    .state_i(state), .want_srv_i(want_srv), .bus_o(bus_in),
    .cmd_o(last_cmd), .srq_o(srq));

  // Free-running 25 MHz clock.
  always #20 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // One APB transfer; an idle cycle follows so no strobe is set twice.
  // The wait for pready has no limit of its own: the watchdog ends a hang.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    clk_i = 0; rst_i = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; irq = 0; state = 5'h01; want_srv = 0;
    error_cnt = 0; n_tests = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, 8'h08, 32'h0);
    chk("cond_idle", 32'h0, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h80000000, {er, rd[30:0]});
    want_srv <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, 8'h00, {8'h00, cmds[i]});
      chk("cmd_word", {8'h00, cmds[i]}, {8'h00, last_cmd});
      apb(1'b0, 8'h04, 32'h0);
      chk("rsp_word", {8'h00, rsps[i]}, {8'h00, rd[23:0]});
      apb(1'b0, 8'h08, 32'h0);
      chk("cond_type", {28'h0, cmds[i][3:0]},
          {28'h0, rd[19:16]});
    end
    chk("srv_flags", 32'h3, {30'h0, rd[2:1]});
    for (int i = 0; i < 5; i++) begin
      state <= sts[i];
      apb(1'b1, 8'h00, 32'h000151);
      apb(1'b0, 8'h04, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk("cond_state", {27'h0, sts[i]}, {27'h0, rd[12:8]});
      chk("cond_flags", {29'h0, i == 4, i > 1 && i < 4, i < 2},
          {29'h0, rd[6:4]});
    end
    want_srv <= 1'b0;
    irq      <= 4'h1;
    repeat (4) @(posedge clk_i);
    apb(1'b0, 8'h08, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, rd[2]});
    apb(1'b1, 8'h0C, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    chk("irq_open", 32'h1, {31'h0, rd[2]});
    irq <= 4'h0;
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h00, 32'h048057);
    apb(1'b0, 8'h04, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("stream_load", 32'h3, rd);
    apb(1'b1, 8'h00, 32'h000054);
    for (int i = 2; i >= 0; i--) begin
      apb(1'b0, 8'h04, 32'h0);
      chk("stream_data", 32'hC3A51E, {8'h00, rd[23:0]});
      apb(1'b0, 8'h10, 32'h0);
      chk("stream_left", 32'(i), rd);
    end
    apb(1'b1, 8'h00, 32'h048057);
    apb(1'b1, 8'h00, 32'h000651);
    apb(1'b0, 8'h10, 32'h0);
    chk("stream_end", 32'h0, rd);
    apb(1'b1, 8'h00, 32'h000056);
    apb(1'b0, 8'h04, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("stream_count_in", 32'h3, rd);
    // Clear, two bytes out, then the odd-byte notice leaves one byte.
    apb(1'b1, 8'h00, 32'h000351);
    apb(1'b1, 8'h00, 32'h00BEEF52);
    apb(1'b1, 8'h00, 32'h000251);
    apb(1'b0, 8'h04, 32'h0);
    chk("odd_count", 32'h008038, rd);
    // Short last inbound transfer of an odd record sets toggle bit 0.
    state <= 5'h11;
    apb(1'b1, 8'h00, 32'h000054);
    apb(1'b0, 8'h04, 32'h0);
    chk("short_in", 32'hC3A589, rd);
    apb(1'b0, 8'h08, 32'h0);
    chk("cond_toggles", 32'h1, {29'h0, rd[15:13]});
    final_report();
  end

  // Watchdog: the sequence needs well under 10000 cycles.
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
endmodule

//--- testbench/iocb_periph_model.sv
// Behavioural peripheral control on the far side of the I/O bus.
// Assumes it sees the design's command word and both strobes.
`timescale 1ns/1ps
module iocb_periph_model #(
  parameter logic [3:0]  CHAN   = 4'h5,
  parameter logic [15:0] DEV_ID = 16'h2A5C, // Arbitrary value.
  parameter logic [23:0] DATA   = 24'hC3A51E,
  parameter logic [8:0]  NBYTES = 9'h009,
  parameter logic        IN_OK  = 1'b1, // Control can send inbound data.
  parameter logic        OUT_OK = 1'b1, // Control can take outbound data.
  parameter logic        ODD_REC = 1'b0, // Record read has odd length.
  parameter logic        HONOUR_END = 1'b1 // Control obeys end-data.
) (
  input  wire logic        clk_i,
  input  wire logic        ca_i,
  input  wire logic        rc_i,
  input  wire logic [23:0] word_i,
  input  wire logic [4:0]  state_i,
  input  wire logic        want_srv_i,
  output logic      [23:0] bus_o,
  output logic      [23:0] cmd_o = 24'h000000,
  output logic             srq_o
);
  logic [23:0] rsp;
  logic [23:0] last_q = 24'h000000;
  logic [4:0]  st;
  logic [8:0]  got_q = 9'h000;
  logic        ca_q = 1'b0;

  // A one-way control passes over the data state of the other way.
  assign st = (!OUT_OK && state_i == 5'h0E) ? 5'h0F :
              (!IN_OK && state_i == 5'h0F) ? 5'h10 : state_i;

  // Response for the command held; status is the state held now, except in a full type-4 data word.
  always_comb begin
    rsp = {16'h0000, st, 3'b000};
    if (cmd_o[3:0] == 4'h1 && (cmd_o[11:8] == 4'h1 || cmd_o[11:8] == 4'h3))
      rsp[23:8] = DEV_ID;
    if (cmd_o[3:0] == 4'h1 && cmd_o[11:8] == 4'h2)
      rsp[23:15] = got_q;
    if (cmd_o[3:0] == 4'h1 && cmd_o[11:8] == 4'h5)
      rsp[23:8] = want_srv_i ? 16'h8000 >> CHAN : 16'h0000;
    // A short last transfer carries status and the odd-record toggle.
    if (cmd_o[3:0] == 4'h4 && st[4:1] == 4'h8)
      rsp = {DATA[23:8], st, 2'b00, ODD_REC};
    else if (cmd_o[3:0] == 4'h4)
      rsp = DATA;
    if (cmd_o[3:0] == 4'h6)
      rsp[23:15] = NBYTES;
  end

  // Keep commands for this channel and the broadcast control type; a
  // control that ignores end-data keeps serving the transfer before it.
  always_ff @(posedge clk_i) begin
    ca_q <= ca_i;
    if (ca_i && (word_i[7:4] == CHAN || word_i[3:0] == 4'h1) &&
        (HONOUR_END || word_i[11:8] != 4'h6 || word_i[3:0] != 4'h1))
      cmd_o <= word_i;
    // Outbound bytes taken since the last clear, counted once a command.
    if (ca_i && !ca_q && word_i[7:4] == CHAN) begin
      if (word_i[3:0] == 4'h2 && OUT_OK)
        got_q <= got_q + 9'h002;
      else if (word_i[3:0] == 4'h1 && word_i[11:8] == 4'h3)
        got_q <= 9'h000;
      else if (word_i[3:0] == 4'h1 && word_i[11:8] == 4'h2 &&
               got_q != 9'h000)
        got_q <= got_q - 9'h001;
    end
    if (rc_i)
      last_q <= rsp;
  end

  // Outside the strobe the bus shows the complement of the last response, so stale data does not linger.
  assign bus_o = rc_i ? rsp : ~last_q;
  assign srq_o = want_srv_i;
endmodule
